//--- logic/mcd_pkg.sv
// Shared constants and types for the control, literal and table instruction decoder
package mcd_pkg;
   // Program word and address widths (8 + 12 address bits in two-word jumps)
   localparam int PC_W = 20;
   localparam int IW_W = 16;

   // Opcode prefixes and patterns
   localparam logic [4:0]  PFX_COND_BR  = 5'h1C;    // 1110 0ccc
   localparam logic [4:0]  PFX_RJUMP    = 5'h1A;    // 1101 0
   localparam logic [4:0]  PFX_RELATIVE_SUBROUTINE_JUMP    = 5'h1B;    // 1101 1
   localparam logic [6:0]  PFX_CALL     = 7'h76;    // 1110 110s
   localparam logic [7:0]  PFX_AJUMP    = 8'hEF;    // 1110 1111
   localparam logic [7:0]  PFX_PTR_LD   = 8'hEE;    // 1110 1110
   localparam logic [3:0]  PFX_SECOND   = 4'hF;     // 1111 operand word
   localparam logic [7:0]  LIT_ADD      = 8'h0F;
   localparam logic [7:0]  LIT_SUB      = 8'h08;
   localparam logic [7:0]  LIT_AND      = 8'h0B;
   localparam logic [7:0]  LIT_OR       = 8'h09;
   localparam logic [7:0]  LIT_XOR      = 8'h0A;
   localparam logic [7:0]  LIT_LOAD     = 8'h0E;
   localparam logic [7:0]  LIT_MUL      = 8'h0D;
   localparam logic [7:0]  LIT_RETURN   = 8'h0C;
   localparam logic [11:0] PFX_BANK_LD  = 12'h010;  // 0000 0001 0000 kkkk
   localparam logic [15:0] OPC_STANDBY  = 16'h0003;
   localparam logic [15:0] OPC_WDT_CLR  = 16'h0004;
   localparam logic [15:0] OPC_PUSH     = 16'h0005;
   localparam logic [15:0] OPC_POP      = 16'h0006;
   localparam logic [14:0] PFX_INT_RET  = 15'h0008;  // 0000 0000 0001 000s
   localparam logic [14:0] PFX_SUB_RET  = 15'h0009;  // 0000 0000 0001 001s
   localparam logic [13:0] PFX_TBL_RD   = 14'h0002;  // 0000 0000 0000 10mm
   localparam logic [13:0] PFX_TBL_WR   = 14'h0003;  // 0000 0000 0000 11mm
   localparam logic [1:0]  PTR_SEL_ZERO = 2'h0;      // Upper ff bits must be 00

   // Cycle counts
   localparam logic [2:0] CYC_ONE     = 3'h1;
   localparam logic [2:0] CYC_TWO     = 3'h2;
   localparam logic [2:0] CYC_TW_LONG = 3'h5;

   // Register map (byte addresses on Wishbone)
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_STATUS  = 4'h4;
   localparam logic [3:0]  REG_COUNT   = 4'h8;
   localparam logic [3:0]  REG_LAST    = 4'hC;
   localparam logic [2:0]  CTRL_RESET  = 3'h1;
   localparam int          CTRL_EN     = 0;
   localparam int          CTRL_PRESC  = 1;
   localparam int          CTRL_TW_INT = 2;

   // ALU status flags, also used as update masks
   typedef struct packed {
      logic carry;
      logic half_carry;
      logic zero;
      logic arith_wrap;
      logic negative;
   } mcd_flags_t;

   localparam mcd_flags_t FLG_NONE  = 5'h00;
   localparam mcd_flags_t FLG_ARITH = 5'h1F;
   localparam mcd_flags_t FLG_LOGIC = 5'h05;

   typedef enum logic [4:0] {
      K_NOP, K_BRANCH, K_RJUMP, K_RELATIVE_SUBROUTINE_JUMP, K_CALL, K_AJUMP, K_PUSH, K_POP,
      K_INT_RET, K_SUB_RET, K_LIT_RET, K_STANDBY, K_WDT_CLR, K_ADD, K_SUB,
      K_AND, K_OR, K_XOR, K_LOAD, K_MUL, K_BANK, K_PTR_LD, K_TBL_RD, K_TBL_WR,
      K_OTHER
   } mcd_kind_t;

   typedef enum logic [1:0] {S_FIRST, S_SECOND, S_FLUSH} mcd_mode_t;

   // One decoded instruction for the datapath
   typedef struct packed {
      logic            valid;
      mcd_kind_t       kind;
      logic [15:0]     word;
      logic [7:0]      literal;
      logic [11:0]     lit12;
      logic [1:0]      ptr_sel;
      logic [1:0]      tbl_mode;
      logic            shadow;
      logic [PC_W-1:0] target;
      logic            pc_load;
      mcd_flags_t      flag_upd;
      logic            sleep_flags_upd;
      logic            int_en_upd;
      logic [2:0]      cycles;
      logic            flush_slot;
   } mcd_dec_t;
endpackage

//--- logic/mcd_decoder.sv
// Control, literal and table instruction decoder with Wishbone status and control
// How it works
// - 1110 0ccc words are conditional branches
// - Taken or jumping ops flush one NOP slot
// - Stray 1111 words decode as no-operation
// - Absolute and relative subroutine jumps, two cycles
// - Absolute and relative unconditional jumps
// - Push and pop return stack, no flags
// - Interrupt return updates enables; plain return
// - Literal return loads working register, two cycles
// - Standby and watchdog clear update sleep flags
// - Literal add and subtract update arithmetic flags
// - Literal logic ops update zero, negative only
// - Literal load and multiply change no flags
// - Bank literal load into low nibble
// - Two-word 12-bit pointer literal load
// - Table read with four pointer modes
// - Table write, four modes, two or five
// - Started internal table write never aborted
// - Port read-modify-write uses sampled pin levels
// - Timer-zero write clears assigned prescaler
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
module mcd_decoder (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   fetch_valid_i,
   input  wire logic [15:0]            fetch_word_i,
   input  wire logic [mcd_pkg::PC_W-1:0] fetch_pc_i,
   output logic                        fetch_ready_o,
   input  wire mcd_pkg::mcd_flags_t    alu_flags_i,
   output mcd_pkg::mcd_dec_t           dec_o,
   input  wire logic [7:0]             port_pins_i,
   input  wire logic                   rmw_port_i,
   output logic [7:0]                  port_operand_o,
   output logic                        use_pins_o,
   input  wire logic                   timer_write_i,
   output logic                        presc_clear_o,
   input  wire logic                   tbl_mem_write_i,
   input  wire logic                   tbl_write_done_i,
   output logic                        tbl_write_busy_o,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [3:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic [31:0]                 wb_dat_o,
   output logic                        wb_ack_o
);
   localparam int PC_W = mcd_pkg::PC_W;

   typedef struct packed {
      mcd_pkg::mcd_mode_t mode;
      logic [15:0]        first_word;
      logic [PC_W-1:0]    first_pc;
      mcd_pkg::mcd_dec_t  dec;
      logic [2:0]         ctrl;
      logic [7:0]         pins_meta;
      logic [7:0]         pins_sync;
      logic [7:0]         port_operand;
      logic               use_pins;
      logic               presc_clear;
      logic               tw_busy;
      logic               fetch_ready;
      logic [15:0]        count;
      logic               wb_ack;
      logic [31:0]        wb_dat;
   } mcd_state_t;

   mcd_state_t s;
   mcd_state_t next_s;

   // Condition test: ccc[2:1] picks the flag, ccc[0] inverts it
   function automatic logic cond_true(input logic [2:0] cc, input mcd_pkg::mcd_flags_t f);
      logic flag;
      flag = 1'b0;
      case (cc[2:1])
         2'h0:    flag = f.zero;
         2'h1:    flag = f.carry;
         2'h2:    flag = f.arith_wrap;
         2'h3:    flag = f.negative;
         default: flag = 1'b0;
      endcase
      return flag ^ cc[0];
   endfunction

   // Single-word decode; two-word heads are finished in the second slot
   function automatic mcd_pkg::mcd_dec_t decode_one(input logic [15:0] w,
                                                    input logic [PC_W-1:0] pc,
                                                    input mcd_pkg::mcd_flags_t f,
                                                    input logic tw_long);
      mcd_pkg::mcd_dec_t d;
      logic [PC_W-1:0]   pc_next;
      d = '0;
      pc_next = pc + PC_W'(1);
      d.valid = 1'b1;
      d.word = w;
      d.literal = w[7:0];
      d.kind = mcd_pkg::K_OTHER;
      d.cycles = mcd_pkg::CYC_ONE;
      d.flag_upd = mcd_pkg::FLG_NONE;
      if (w[15:11] == mcd_pkg::PFX_COND_BR) begin
         d.kind = mcd_pkg::K_BRANCH;
         d.target = pc_next + {{(PC_W-8){w[7]}}, w[7:0]};
         d.pc_load = cond_true(w[10:8], f);
         d.cycles = d.pc_load ? mcd_pkg::CYC_TWO : mcd_pkg::CYC_ONE;
      end else if (w[15:11] == mcd_pkg::PFX_RJUMP || w[15:11] == mcd_pkg::PFX_RELATIVE_SUBROUTINE_JUMP) begin
         d.kind = w[11] ? mcd_pkg::K_RELATIVE_SUBROUTINE_JUMP : mcd_pkg::K_RJUMP;
         d.target = pc_next + {{(PC_W-11){w[10]}}, w[10:0]};
         d.pc_load = 1'b1;
         d.cycles = mcd_pkg::CYC_TWO;
      end else if (w[15:12] == mcd_pkg::PFX_SECOND) begin
         d.kind = mcd_pkg::K_NOP;
      end else if (w[15:2] == mcd_pkg::PFX_TBL_RD || w[15:2] == mcd_pkg::PFX_TBL_WR) begin
         d.kind = w[2] ? mcd_pkg::K_TBL_WR : mcd_pkg::K_TBL_RD;
         d.tbl_mode = w[1:0];
         d.cycles = (w[2] && tw_long) ? mcd_pkg::CYC_TW_LONG : mcd_pkg::CYC_TWO;
      end else if (w[15:1] == mcd_pkg::PFX_INT_RET || w[15:1] == mcd_pkg::PFX_SUB_RET) begin
         d.kind = w[1] ? mcd_pkg::K_SUB_RET : mcd_pkg::K_INT_RET;
         d.shadow = w[0];
         d.int_en_upd = ~w[1];
         d.pc_load = 1'b1;
         d.cycles = mcd_pkg::CYC_TWO;
      end else if (w[15:4] == mcd_pkg::PFX_BANK_LD) begin
         d.kind = mcd_pkg::K_BANK;
         d.literal = {4'h0, w[3:0]};
      end else if (w == mcd_pkg::OPC_PUSH || w == mcd_pkg::OPC_POP) begin
         d.kind = w[1] ? mcd_pkg::K_POP : mcd_pkg::K_PUSH;
      end else if (w == mcd_pkg::OPC_STANDBY || w == mcd_pkg::OPC_WDT_CLR) begin
         d.kind = w[2] ? mcd_pkg::K_WDT_CLR : mcd_pkg::K_STANDBY;
         d.sleep_flags_upd = 1'b1;
      end else begin
         case (w[15:8])
            mcd_pkg::LIT_ADD: begin
               d.kind = mcd_pkg::K_ADD;
               d.flag_upd = mcd_pkg::FLG_ARITH;
            end
            mcd_pkg::LIT_SUB: begin
               d.kind = mcd_pkg::K_SUB;
               d.flag_upd = mcd_pkg::FLG_ARITH;
            end
            mcd_pkg::LIT_AND: begin
               d.kind = mcd_pkg::K_AND;
               d.flag_upd = mcd_pkg::FLG_LOGIC;
            end
            mcd_pkg::LIT_OR: begin
               d.kind = mcd_pkg::K_OR;
               d.flag_upd = mcd_pkg::FLG_LOGIC;
            end
            mcd_pkg::LIT_XOR: begin
               d.kind = mcd_pkg::K_XOR;
               d.flag_upd = mcd_pkg::FLG_LOGIC;
            end
            mcd_pkg::LIT_LOAD: d.kind = mcd_pkg::K_LOAD;
            mcd_pkg::LIT_MUL:  d.kind = mcd_pkg::K_MUL;
            mcd_pkg::LIT_RETURN: begin
               d.kind = mcd_pkg::K_LIT_RET;
               d.pc_load = 1'b1;
               d.cycles = mcd_pkg::CYC_TWO;
            end
            default: d.kind = (w == '0) ? mcd_pkg::K_NOP : mcd_pkg::K_OTHER;
         endcase
      end
      return d;
   endfunction

   // Two-word heads wait for their operand word
   function automatic logic is_head(input logic [15:0] w);
      return w[15:9] == mcd_pkg::PFX_CALL || w[15:8] == mcd_pkg::PFX_AJUMP ||
             (w[15:8] == mcd_pkg::PFX_PTR_LD && w[7:6] == mcd_pkg::PTR_SEL_ZERO);
   endfunction

   logic accept;
   logic wb_req;
   assign accept = fetch_valid_i && s.fetch_ready;
   assign wb_req = wb_cyc_i && wb_stb_i && !s.wb_ack;

   // Next-state logic for decode, side effects and register bus
   always_comb begin
      next_s = s;
      next_s.dec.valid = 1'b0;
      next_s.presc_clear = 1'b0;
      next_s.wb_ack = 1'b0;
      // Two flops before anything looks at the pins
      next_s.pins_meta = port_pins_i;
      next_s.pins_sync = s.pins_meta;
      next_s.use_pins = rmw_port_i;
      if (rmw_port_i) begin
         next_s.port_operand = s.pins_sync;
      end
      // Prescaler only cleared when software says it is assigned to timer zero
      next_s.presc_clear = timer_write_i && s.ctrl[mcd_pkg::CTRL_PRESC];
      // Start wins over done; nothing else ends a running write
      if (tbl_mem_write_i) begin
         next_s.tw_busy = 1'b1;
      end else if (tbl_write_done_i) begin
         next_s.tw_busy = 1'b0;
      end
      if (accept) begin
         next_s.count = s.count + 16'h0001;
         case (s.mode)
            mcd_pkg::S_FIRST: begin
               if (is_head(fetch_word_i)) begin
                  next_s.mode = mcd_pkg::S_SECOND;
                  next_s.first_word = fetch_word_i;
                  next_s.first_pc = fetch_pc_i;
               end else begin
                  next_s.dec = decode_one(fetch_word_i, fetch_pc_i, alu_flags_i,
                                          s.ctrl[mcd_pkg::CTRL_TW_INT]);
                  next_s.mode = next_s.dec.pc_load ? mcd_pkg::S_FLUSH : mcd_pkg::S_FIRST;
               end
            end
            mcd_pkg::S_SECOND: begin
               if (fetch_word_i[15:12] == mcd_pkg::PFX_SECOND) begin
                  next_s.dec = '0;
                  next_s.dec.valid = 1'b1;
                  next_s.dec.word = s.first_word;
                  next_s.dec.cycles = mcd_pkg::CYC_TWO;
                  next_s.dec.flag_upd = mcd_pkg::FLG_NONE;
                  if (s.first_word[15:8] == mcd_pkg::PFX_PTR_LD) begin
                     next_s.dec.kind = mcd_pkg::K_PTR_LD;
                     next_s.dec.ptr_sel = s.first_word[5:4];
                     next_s.dec.lit12 = {s.first_word[3:0], fetch_word_i[7:0]};
                     next_s.mode = mcd_pkg::S_FIRST;
                  end else begin
                     // Operand word supplies the upper 12 address bits
                     next_s.dec.kind = (s.first_word[15:8] == mcd_pkg::PFX_AJUMP) ?
                                       mcd_pkg::K_AJUMP : mcd_pkg::K_CALL;
                     next_s.dec.shadow = s.first_word[8];
                     next_s.dec.target = {fetch_word_i[11:0], s.first_word[7:0]};
                     next_s.dec.pc_load = 1'b1;
                     next_s.mode = mcd_pkg::S_FLUSH;
                  end
               end else begin
                  // Orphan head: dropped, this word decodes on its own
                  next_s.dec = decode_one(fetch_word_i, fetch_pc_i, alu_flags_i,
                                          s.ctrl[mcd_pkg::CTRL_TW_INT]);
                  next_s.mode = next_s.dec.pc_load ? mcd_pkg::S_FLUSH : mcd_pkg::S_FIRST;
               end
            end
            mcd_pkg::S_FLUSH: begin
               // Prefetched word after a jump runs as a no-operation
               next_s.dec = '0;
               next_s.dec.valid = 1'b1;
               next_s.dec.kind = mcd_pkg::K_NOP;
               next_s.dec.word = fetch_word_i;
               next_s.dec.cycles = mcd_pkg::CYC_ONE;
               next_s.dec.flush_slot = 1'b1;
               next_s.mode = mcd_pkg::S_FIRST;
            end
            default: next_s.mode = mcd_pkg::S_FIRST;
         endcase
      end
      // Fetch stalls while an internal table write runs
      next_s.fetch_ready = next_s.ctrl[mcd_pkg::CTRL_EN] && !next_s.tw_busy;
      // Wishbone slave: one wait state, unmapped reads zero, writes ignored
      if (wb_req) begin
         next_s.wb_ack = 1'b1;
         next_s.wb_dat = 32'h0000_0000;
         case (wb_adr_i)
            mcd_pkg::REG_CTRL: begin
               if (wb_we_i && wb_sel_i[0]) begin
                  next_s.ctrl = wb_dat_i[2:0];
                  next_s.fetch_ready = wb_dat_i[mcd_pkg::CTRL_EN] && !next_s.tw_busy;
               end
               next_s.wb_dat = {29'h0, s.ctrl};
            end
            mcd_pkg::REG_STATUS: next_s.wb_dat = {29'h0, s.tw_busy, s.mode};
            mcd_pkg::REG_COUNT:  next_s.wb_dat = {16'h0000, s.count};
            mcd_pkg::REG_LAST:   next_s.wb_dat = {16'h0000, s.dec.word};
            default:             next_s.wb_dat = 32'h0000_0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.mode <= mcd_pkg::S_FIRST;
         s.ctrl <= mcd_pkg::CTRL_RESET;
         s.fetch_ready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign fetch_ready_o    = s.fetch_ready;
   assign dec_o            = s.dec;
   assign port_operand_o   = s.port_operand;
   assign use_pins_o       = s.use_pins;
   assign presc_clear_o    = s.presc_clear;
   assign tbl_write_busy_o = s.tw_busy;
   assign wb_dat_o         = s.wb_dat;
   assign wb_ack_o         = s.wb_ack;

   // Checks on decoded output and side effects
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_branch_cycles: assert property (dec_o.valid && dec_o.kind == mcd_pkg::K_BRANCH |->
         dec_o.cycles == (dec_o.pc_load ? 3'h2 : 3'h1))
      else $error("branch cycle count wrong");
   a_flush_follows: assert property (dec_o.valid && dec_o.pc_load |->
         s.mode == mcd_pkg::S_FLUSH)
      else $error("no flush slot after jump");
   a_stray_ones: assert property (accept && s.mode == mcd_pkg::S_FIRST &&
         fetch_word_i[15:12] == 4'hF |=> dec_o.valid && dec_o.kind == mcd_pkg::K_NOP)
      else $error("stray operand word not a nop");
   a_call_target: assert property (accept && s.mode == mcd_pkg::S_SECOND &&
         fetch_word_i[15:12] == 4'hF && s.first_word[15:9] == 7'h76 |=>
         dec_o.kind == mcd_pkg::K_CALL && dec_o.cycles == 3'h2 &&
         dec_o.target == {$past(fetch_word_i[11:0]), $past(s.first_word[7:0])})
      else $error("call target wrong");
   a_rel_target: assert property (accept && s.mode == mcd_pkg::S_FIRST &&
         fetch_word_i[15:12] == 4'hD |=> dec_o.target == $past(fetch_pc_i) + 20'h1 +
         {{9{$past(fetch_word_i[10])}}, $past(fetch_word_i[10:0])})
      else $error("relative target wrong");
   a_stack_plain: assert property (dec_o.valid && (dec_o.kind == mcd_pkg::K_PUSH ||
         dec_o.kind == mcd_pkg::K_POP) |-> dec_o.flag_upd == 5'h00 && dec_o.cycles == 3'h1)
      else $error("stack op flags or cycles wrong");
   a_int_return: assert property (dec_o.valid && dec_o.kind == mcd_pkg::K_INT_RET |->
         dec_o.int_en_upd && dec_o.cycles == 3'h2)
      else $error("interrupt return wrong");
   a_logic_flags: assert property (dec_o.valid && (dec_o.kind == mcd_pkg::K_AND ||
         dec_o.kind == mcd_pkg::K_XOR) |-> dec_o.flag_upd == 5'h05)
      else $error("logic op flag mask wrong");
   a_tw_holds: assert property (s.tw_busy && !tbl_write_done_i |=>
         tbl_write_busy_o && !fetch_ready_o)
      else $error("table write aborted");
   a_presc_clear: assert property (timer_write_i && s.ctrl[1] |=> presc_clear_o)
      else $error("prescaler not cleared");
   a_pin_source: assert property (rmw_port_i |=> use_pins_o &&
         port_operand_o == $past(s.pins_sync))
      else $error("port operand not from pins");

   // Decode shape of the remaining control, literal and table kinds
   a_ajump_decode: assert property (accept && s.mode == mcd_pkg::S_SECOND &&
         fetch_word_i[15:12] == 4'hF && s.first_word[15:8] == 8'hEF |=>
         dec_o.kind == mcd_pkg::K_AJUMP && dec_o.pc_load && dec_o.cycles == 3'h2)
      else $error("absolute jump decode wrong");
   a_lit_return: assert property (dec_o.valid && dec_o.kind == mcd_pkg::K_LIT_RET |->
         dec_o.pc_load && dec_o.cycles == 3'h2 && dec_o.flag_upd == 5'h00)
      else $error("literal return wrong");
   a_sleep_flags: assert property (dec_o.valid && (dec_o.kind == mcd_pkg::K_STANDBY ||
         dec_o.kind == mcd_pkg::K_WDT_CLR) |-> dec_o.sleep_flags_upd && dec_o.cycles == 3'h1)
      else $error("sleep flag update wrong");
   a_arith_flags: assert property (dec_o.valid && (dec_o.kind == mcd_pkg::K_ADD ||
         dec_o.kind == mcd_pkg::K_SUB) |-> dec_o.flag_upd == 5'h1F && dec_o.cycles == 3'h1)
      else $error("arithmetic flag mask wrong");
   a_plain_lits: assert property (dec_o.valid && (dec_o.kind == mcd_pkg::K_LOAD ||
         dec_o.kind == mcd_pkg::K_MUL) |-> dec_o.flag_upd == 5'h00 && dec_o.cycles == 3'h1)
      else $error("load or multiply flags wrong");
   a_bank_nibble: assert property (dec_o.valid && dec_o.kind == mcd_pkg::K_BANK |->
         dec_o.literal[7:4] == 4'h0 && dec_o.literal[3:0] == dec_o.word[3:0])
      else $error("bank literal wrong");
   a_ptr_load: assert property (accept && s.mode == mcd_pkg::S_SECOND &&
         fetch_word_i[15:12] == 4'hF && s.first_word[15:8] == 8'hEE |=>
         dec_o.kind == mcd_pkg::K_PTR_LD && dec_o.cycles == 3'h2 &&
         dec_o.lit12 == {$past(s.first_word[3:0]), $past(fetch_word_i[7:0])})
      else $error("pointer literal load wrong");
   a_tbl_read: assert property (dec_o.valid && dec_o.kind == mcd_pkg::K_TBL_RD |->
         dec_o.cycles == 3'h2 && dec_o.tbl_mode == dec_o.word[1:0])
      else $error("table read decode wrong");
   // Long count depends on the control bit at accept, so either count is legal here
   a_tbl_write: assert property (dec_o.valid && dec_o.kind == mcd_pkg::K_TBL_WR |->
         (dec_o.cycles == 3'h2 || dec_o.cycles == 3'h5) && dec_o.tbl_mode == dec_o.word[1:0])
      else $error("table write decode wrong");
endmodule

//--- tb/mcd_fetch_model.sv
// Program memory fetch model that hands words to the decoder
`timescale 1ns/1ns
module mcd_fetch_model (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   input  wire logic   ready_i,
   output logic        valid_o,
   output logic [15:0] word_o,
   output logic [19:0] pc_o,
   output logic [19:0] tpc_o
);
   logic [15:0] q[$];
   task automatic put(input logic [15:0] w);
      q.push_back(w);
   endtask
   // Word held until taken; idle bus toggles so a stale word never looks fresh
   always @(posedge clk_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
         word_o  <= 16'h0000;
         pc_o    <= 20'h00100;
      end else if (!valid_o || ready_i) begin
         if (valid_o) begin
            tpc_o <= pc_o;
            pc_o  <= pc_o + 20'h00001;
         end
         valid_o <= q.size() > 0;
         word_o  <= q.size() > 0 ? q.pop_front() : ~word_o;
      end
   end
endmodule

//--- tb/mcd_decoder_tb_top.sv
// Self-checking bench for the control, literal and table decoder
`timescale 1ns/1ns
module mcd_decoder_tb_top;
   logic               clk_i, rst_i, rdy, fv, rmw, tw, tms, tmd, busy, usep, pcl, cyc, stb, we, ack;
   logic [15:0]        fw;
   logic [19:0]        fpc, tpc;
   logic [7:0]         pins, pop;
   logic [3:0]         adr;
   logic [31:0]        wd, rd, q;
   mcd_pkg::mcd_flags_t fl;
   mcd_pkg::mcd_dec_t  dec;
   int                 n_fail, tests_run;
   logic [7:0]  lit[7] = '{8'h0F, 8'h08, 8'h0B, 8'h09, 8'h0A, 8'h0E, 8'h0D};
   logic [15:0] sw[7]  = '{16'h0005, 16'h0006, 16'h0011, 16'h0013, 16'h0C33, 16'h0003, 16'h0004};
   mcd_fetch_model fm (.clk_i(clk_i), .rst_i(rst_i), .ready_i(rdy), .valid_o(fv), .word_o(fw),
      .pc_o(fpc), .tpc_o(tpc));
   mcd_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .fetch_valid_i(fv), .fetch_word_i(fw),
      .fetch_pc_i(fpc), .fetch_ready_o(rdy), .alu_flags_i(fl), .dec_o(dec), .port_pins_i(pins),
      .rmw_port_i(rmw), .port_operand_o(pop), .use_pins_o(usep), .timer_write_i(tw),
      .presc_clear_o(pcl), .tbl_mem_write_i(tms), .tbl_write_done_i(tmd),
      .tbl_write_busy_o(busy), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack));
   task automatic end_of_test();
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tmo();
      n_fail++;
      $display("BAD %0t wait ran out", $time);
      end_of_test();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // Classic single Wishbone cycle; read data taken at the ack edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 40);
      q = rd;
      {cyc, stb} <= 2'b00;
      if (i == 40)
         tmo();
   endtask
   // Queue one word and wait for its decode slot
   task automatic op(input logic [15:0] w, input logic [31:0] k, input logic [31:0] c);
      int i;
      fm.put(w);
      i = 0;
      do begin
         @(negedge clk_i);
         i++;
      end while (dec.valid !== 1'b1 && i < 40);
      if (i == 40)
         tmo();
      chk(dec.kind, k);
      chk(dec.cycles, c);
   endtask
   task automatic flush();
      op(16'h0000, mcd_pkg::K_NOP, 1);
      chk(dec.flush_slot, 1);
   endtask
   // Pulse the timer write and a port read-modify-write together
   task automatic fx(input logic [7:0] p, input logic e);
      @(posedge clk_i);
      pins <= p;
      repeat (3) @(posedge clk_i);
      {tw, rmw} <= 2'b11;
      @(posedge clk_i);
      {tw, rmw} <= 2'b00;
      @(negedge clk_i);
      chk(pcl, e);
      chk({usep, pop}, {1'b1, p});
   endtask
   initial begin
      clk_i = 0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      #400000;
      tmo();
   end
   initial begin
      {rst_i, rmw, tw, tms, tmd, cyc, stb, we, adr, wd, pins, fl} = {1'b1, 56'h0};
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      wb(0, 4'h0, 0);
      chk(q, 1);
      wb(1, 4'h0, 32'h3);
      wb(0, 4'h2, 0);
      chk(q, 0);
      for (int i = 0; i < 7; i++) begin
         op({lit[i], 8'h5A}, mcd_pkg::K_ADD + i, 1);
         chk(dec.flag_upd, i < 2 ? 5'h1F : i < 5 ? 5'h05 : 5'h00);
         chk(dec.literal, 8'h5A);
      end
      for (int i = 0; i < 7; i++) begin
         op(sw[i], mcd_pkg::K_PUSH + i, (i > 1 && i < 5) ? 2 : 1);
         chk({dec.sleep_flags_upd, dec.int_en_upd, dec.flag_upd}, {i > 4, i == 2, 5'h0});
         if (i > 1 && i < 5)
            flush();
      end
      for (int f = 0; f < 2; f++)
         for (int c = 0; c < 8; c++) begin
            @(posedge clk_i);
            fl <= f[0] ? 5'h1F : 5'h00;
            op({5'h1C, c[2:0], 8'hFE}, mcd_pkg::K_BRANCH, (c[0] ^ f[0]) ? 2 : 1);
            chk(dec.pc_load, c[0] ^ f[0]);
            if (c[0] ^ f[0]) begin
               chk(dec.target, tpc - 20'h1);
               flush();
            end
         end
      fm.put(16'hEC34);
      op(16'hF567, mcd_pkg::K_CALL, 2);
      chk(dec.target, 20'h56734);
      flush();
      fm.put(16'hEF12);
      op(16'hFABC, mcd_pkg::K_AJUMP, 2);
      chk(dec.target, 20'hABC12);
      flush();
      op(16'hDFFF, mcd_pkg::K_RELATIVE_SUBROUTINE_JUMP, 2);
      chk(dec.target, tpc);
      flush();
      op(16'hD005, mcd_pkg::K_RJUMP, 2);
      chk(dec.target, tpc + 20'h6);
      flush();
      fm.put(16'hEE25);
      op(16'hF0AB, mcd_pkg::K_PTR_LD, 2);
      chk({dec.ptr_sel, dec.lit12}, 14'h25AB);
      op(16'hF123, mcd_pkg::K_NOP, 1);
      op(16'h0107, mcd_pkg::K_BANK, 1);
      chk(dec.literal, 8'h07);
      for (int m = 0; m < 4; m++) begin
         op({14'h0002, m[1:0]}, mcd_pkg::K_TBL_RD, 2);
         chk(dec.tbl_mode, m);
         op({14'h0003, m[1:0]}, mcd_pkg::K_TBL_WR, 2);
         chk(dec.tbl_mode, m);
      end
      fx(8'h3C, 1);
      wb(1, 4'h0, 32'h5);
      op(16'h000C, mcd_pkg::K_TBL_WR, 5);
      fx(8'hC3, 0);
      @(posedge clk_i);
      tms <= 1;
      @(posedge clk_i);
      tms <= 0;
      repeat (3) @(negedge clk_i);
      chk({busy, rdy}, 2'b10);
      @(posedge clk_i);
      tmd <= 1;
      @(posedge clk_i);
      tmd <= 0;
      @(negedge clk_i);
      chk({busy, rdy}, 2'b01);
      end_of_test();
   end
endmodule
